// ==== cscg_top.sv ====
// system controller, bus buffer and clock generator for an eight-bit processor
//
// Contract
// - capture six status bits from the data bus on each status strobe.
// - gate latched status with data in, write and hold acknowledge into commands.
// - bus enable high releases all system-side data outputs.
// - buffer direction follows the processor's data bus in strobe.
// - peripherals place an instruction byte during irq acknowledge.
// - auto restart mode supplies the restart-seven opcode on each acknowledge.
// - status strobe pulses low once per machine cycle from cycle sync.
// - status strobe is also asserted while system reset is asserted.
// - a power-on reset pulse is generated automatically after reset release.
// - system reset stays asserted while reset request is low.
// - ready request is synchronised to processor phases before reaching the cpu.
// - processor clock equals oscillator divided by nine.
// - two non-overlapping phases plus a logic copy of phase two.
`timescale 1ns/1ps
`include "cscg_cfg.svh"
module cscg_top
	import cscg_pkg::*;
#(
	parameter int POR_CYCLES = `CSCG_POR_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       reset_request_n,
	input  wire logic       ready_request,
	input  wire logic       cycle_sync,
	input  wire logic       data_bus_in_strobe,
	input  wire logic       processor_write_strobe_n,
	input  wire logic       hold_acknowledge,
	input  wire logic       bus_drive_enable,
	input  wire logic       auto_restart,
	input  wire logic [7:0] cpu_data_in,
	output logic      [7:0] cpu_data_out,
	output logic            cpu_data_oe,
	input  wire logic [7:0] sys_data_in,
	output logic      [7:0] sys_data_out,
	output logic            sys_data_oe,
	output logic            phase_one,
	output logic            phase_two,
	output logic            phase_two_ttl,
	output logic            status_strobe_n,
	output logic            system_reset,
	output logic            ready_to_cpu,
	output logic            memory_read_cmd_n,
	output logic            memory_write_cmd_n,
	output logic            port_read_cmd_n,
	output logic            port_write_cmd_n,
	output logic            irq_acknowledge_cmd_n
);
	logic [3:0]   div_r;
	logic         ph1_r;
	logic         ph2_r;
	logic         ph2_ttl_r;
	logic         ph2_fall;
	cscg_rst_e    rst_state_r;
	logic [15:0]  por_cnt_r;
	logic         por_done;
	logic         rdy_meta_r;
	logic         rdy_sync_r;
	logic         rdy_out_r;
	cscg_status_s status_r;
	logic         dec_irq_acknowledge_cmd;
	logic         dec_mem_rd;
	logic         dec_io_wr;
	logic         dec_mem_wr;
	logic         dec_io_rd;
	cscg_cmd_s    cmd;
	logic [1:0]   rd_cmd_r;
	logic [1:0]   wr_cmd_r;
	logic         ack_cmd_r;
	logic         to_cpu;
	logic [7:0]   cpu_drive;

	// divide by nine, phase one for two counts, phase two for four
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			div_r <= 4'h0;
		else if (div_r == `CSCG_DIV_COUNT - 4'h1)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end

	// phase one, with a gap of one count before phase two starts
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ph1_r <= 1'b0;
		else
			ph1_r <= (div_r >= `CSCG_PH1_START) && (div_r < `CSCG_PH1_END);
	end

	// phase two, ending before the count wraps to phase one again
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ph2_r <= 1'b0;
		else
			ph2_r <= (div_r >= `CSCG_PH2_START) && (div_r < `CSCG_PH2_END);
	end

	// logic-level copy of phase two, its own flop so its load stays apart
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ph2_ttl_r <= 1'b0;
		else
			ph2_ttl_r <= (div_r >= `CSCG_PH2_START) && (div_r < `CSCG_PH2_END);
	end

	assign phase_one     = ph1_r;
	assign phase_two     = ph2_r;
	assign phase_two_ttl = ph2_ttl_r;
	assign ph2_fall      = (div_r == `CSCG_PH2_END);

	assign por_done = (por_cnt_r == 16'(POR_CYCLES - 1));

	// power-on counter, runs once after nrst is released
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			por_cnt_r <= 16'h0000;
		else if (rst_state_r == CSCG_POR && !por_done)
			por_cnt_r <= por_cnt_r + 16'h0001;
	end

	// power-on pulse then level reset following the request input
	// the counter is never cleared again, so a later request gives a level only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rst_state_r <= CSCG_POR;
		else
		begin
			case (rst_state_r)
				CSCG_POR:
				begin
					// automatic reset after power comes up
					if (por_done)
						rst_state_r <= CSCG_RUN;
				end
				CSCG_RUN:
				begin
					if (!reset_request_n)
						rst_state_r <= CSCG_HOLD;
				end
				CSCG_HOLD:
				begin
					// held while request stays low
					if (reset_request_n)
						rst_state_r <= CSCG_RUN;
				end
				default:
					rst_state_r <= CSCG_POR;
			endcase
		end
	end

	assign system_reset = (rst_state_r != CSCG_RUN) || !reset_request_n;

	// strobe while sync is high during phase one, and during reset
	// kept combinational so the latch loads inside the same phase-one window
	assign status_strobe_n = !((cycle_sync && ph1_r) || system_reset);

	// two flops take the asynchronous request into the clk domain
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdy_meta_r <= 1'b0;
			rdy_sync_r <= 1'b0;
		end
		else
		begin
			rdy_meta_r <= ready_request;
			rdy_sync_r <= rdy_meta_r;
		end
	end

	// released at the end of phase two so it never moves inside a phase
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdy_out_r <= 1'b0;
		else if (ph2_fall)
			rdy_out_r <= rdy_sync_r;
	end

	assign ready_to_cpu = rdy_out_r;

	// status latch loaded from processor data bus on strobe
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			status_r <= '0;
		else if (!status_strobe_n)
		begin
			status_r.intack   <= cpu_data_in[`CSCG_ST_IRQ_ACKNOWLEDGE_CMD];
			status_r.write_n  <= cpu_data_in[`CSCG_ST_WO_N];
			status_r.stack    <= cpu_data_in[`CSCG_ST_STACK];
			status_r.halt_ack <= cpu_data_in[`CSCG_ST_HLTA];
			status_r.out_cyc  <= cpu_data_in[`CSCG_ST_OUT];
			status_r.mem_read <= cpu_data_in[`CSCG_ST_MEMR];
		end
	end

	// cycle type from the latched status, in priority order, so at most one is set
	assign dec_irq_acknowledge_cmd   = status_r.intack;
	assign dec_mem_rd = !status_r.intack && status_r.mem_read;
	assign dec_io_wr  = !status_r.intack && !status_r.mem_read && !status_r.write_n
		&& status_r.out_cyc;
	assign dec_mem_wr = !status_r.intack && !status_r.mem_read && !status_r.write_n
		&& !status_r.out_cyc;
	// a halt cycle gives no port read even though its write bit is high
	assign dec_io_rd  = !status_r.intack && !status_r.mem_read && status_r.write_n
		&& !status_r.halt_ack;

	// command gating, blocked under hold acknowledge and while status loads
	always_comb
	begin
		cmd = '0;
		if (!hold_acknowledge && status_strobe_n)
		begin
			cmd.irq_acknowledge_cmd   = dec_irq_acknowledge_cmd && data_bus_in_strobe;
			cmd.mem_rd = dec_mem_rd && data_bus_in_strobe;
			cmd.io_rd  = dec_io_rd && data_bus_in_strobe;
			cmd.mem_wr = dec_mem_wr && !processor_write_strobe_n;
			cmd.io_wr  = dec_io_wr && !processor_write_strobe_n;
		end
	end

	// read commands, one clock after the read strobe
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rd_cmd_r <= 2'h0;
		else
			rd_cmd_r <= {cmd.mem_rd, cmd.io_rd};
	end

	// write commands, one clock after the write strobe
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wr_cmd_r <= 2'h0;
		else
			wr_cmd_r <= {cmd.mem_wr, cmd.io_wr};
	end

	// interrupt acknowledge, one clock after the read strobe
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ack_cmd_r <= 1'b0;
		else
			ack_cmd_r <= cmd.irq_acknowledge_cmd;
	end

	// hold acknowledge cuts the commands at once, not a clock later
	assign memory_read_cmd_n     = !(rd_cmd_r[1] && !hold_acknowledge);
	assign memory_write_cmd_n    = !(wr_cmd_r[1] && !hold_acknowledge);
	assign port_read_cmd_n       = !(rd_cmd_r[0] && !hold_acknowledge);
	assign port_write_cmd_n      = !(wr_cmd_r[0] && !hold_acknowledge);
	// peripheral answers this with an instruction byte unless auto restart
	assign irq_acknowledge_cmd_n = !(ack_cmd_r && !auto_restart && !hold_acknowledge);

	// direction from the data bus in strobe: toward cpu while it reads
	assign to_cpu    = data_bus_in_strobe && !hold_acknowledge;
	// restart seven forced in place of the bus on interrupt acknowledge in auto restart mode
	assign cpu_drive = (status_r.intack && auto_restart) ? `CSCG_RESTART_SEVEN_OPCODE_OPCODE : sys_data_in;

	// data toward the processor, restart opcode or system bus byte
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cpu_data_out <= 8'h00;
		else
			cpu_data_out <= cpu_drive;
	end

	// data toward the system bus, the processor's write byte
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			sys_data_out <= 8'h00;
		else
			sys_data_out <= cpu_data_in;
	end

	// both enables are combinational so direction turns with the strobes

	assign cpu_data_oe = to_cpu;
	// released whenever bus enable is high
	assign sys_data_oe = !bus_drive_enable && !to_cpu && !status_r.write_n
		&& !hold_acknowledge;
endmodule // cscg_top

// ==== cscg_cfg.svh ====
// constants for the cpu system controller and clock generator
`ifndef CSCG_CFG_SVH
`define CSCG_CFG_SVH
`define CSCG_DIV_COUNT      4'h9
`define CSCG_PH1_START      4'h0
`define CSCG_PH1_END        4'h2
`define CSCG_PH2_START      4'h3
`define CSCG_PH2_END        4'h7
`define CSCG_POR_NS         1000
`define CSCG_CLK_NS         25
`define CSCG_POR_CYCLES     ((`CSCG_POR_NS + `CSCG_CLK_NS - 1) / `CSCG_CLK_NS)
`define CSCG_RESTART_SEVEN_OPCODE_OPCODE    8'hFF
`define CSCG_ST_IRQ_ACKNOWLEDGE_CMD        0
`define CSCG_ST_WO_N        1
`define CSCG_ST_STACK       2
`define CSCG_ST_HLTA        3
`define CSCG_ST_OUT         4
`define CSCG_ST_MEMR        5
`define CSCG_ST_INP         6
`endif

// ==== cscg_pkg.sv ====
// types for the cpu system controller and clock generator
package cscg_pkg;
	typedef struct packed {
		logic intack;
		logic write_n;
		logic stack;
		logic halt_ack;
		logic out_cyc;
		logic mem_read;
	} cscg_status_s;
	typedef struct packed {
		logic mem_rd;
		logic mem_wr;
		logic io_rd;
		logic io_wr;
		logic irq_acknowledge_cmd;
	} cscg_cmd_s;
	typedef enum logic [2:0] {
		CSCG_POR  = 3'h1,
		CSCG_RUN  = 3'h2,
		CSCG_HOLD = 3'h4
	} cscg_rst_e;
endpackage

// ==== cscg_top_asserts.sv ====
// concurrent checks on the controller and clock generator ports
`timescale 1ns/1ps
module cscg_top_asserts
(
	input wire logic	clk,
	input wire logic	nrst,
	input wire logic	reset_request_n,
	input wire logic	cycle_sync,
	input wire logic	hold_acknowledge,
	input wire logic	bus_drive_enable,
	input wire logic	auto_restart,
	input wire logic	phase_one,
	input wire logic	phase_two,
	input wire logic	status_strobe_n,
	input wire logic	system_reset,
	input wire logic	sys_data_oe,
	input wire logic	memory_read_cmd_n,
	input wire logic	memory_write_cmd_n,
	input wire logic	port_read_cmd_n,
	input wire logic	port_write_cmd_n,
	input wire logic	irq_acknowledge_cmd_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic [3:0] rw_n = {memory_read_cmd_n, memory_write_cmd_n, port_read_cmd_n, port_write_cmd_n};
	a_rst_strobe: assert property (system_reset |-> !status_strobe_n) else $error("strobe");
	a_sync_strobe: assert property (cycle_sync && phase_one |-> !status_strobe_n) else $error("sync");
	a_bus_release: assert property (bus_drive_enable |-> !sys_data_oe) else $error("bus");
	a_one_cmd: assert property ($onehot0(~rw_n)) else $error("two cmds");
	a_hold_quiet: assert property (hold_acknowledge |-> &rw_n) else $error("hold");
	a_no_overlap: assert property (!(phase_one && phase_two)) else $error("overlap");
	a_phase_period: assert property ($rose(phase_one) |-> ##9 $rose(phase_one)) else $error("div");
	a_auto_irq_acknowledge_cmd: assert property (auto_restart [*2] |-> irq_acknowledge_cmd_n) else $error("irq_acknowledge_cmd");
	a_req_reset: assert property (!reset_request_n [*3] |-> system_reset) else $error("req");
	cover property ($fell(memory_read_cmd_n));
	cover property ($fell(port_write_cmd_n));
	cover property ($fell(system_reset));
endmodule // cscg_top_asserts
bind cscg_top cscg_top_asserts u_chk (
	.clk                   (clk),
	.nrst                  (nrst),
	.reset_request_n       (reset_request_n),
	.cycle_sync            (cycle_sync),
	.hold_acknowledge      (hold_acknowledge),
	.bus_drive_enable      (bus_drive_enable),
	.auto_restart          (auto_restart),
	.phase_one             (phase_one),
	.phase_two             (phase_two),
	.status_strobe_n       (status_strobe_n),
	.system_reset          (system_reset),
	.sys_data_oe           (sys_data_oe),
	.memory_read_cmd_n     (memory_read_cmd_n),
	.memory_write_cmd_n    (memory_write_cmd_n),
	.port_read_cmd_n       (port_read_cmd_n),
	.port_write_cmd_n      (port_write_cmd_n),
	.irq_acknowledge_cmd_n (irq_acknowledge_cmd_n)
);

// ==== cscg_cpu_model.sv ====
// processor-side machine cycle model
`timescale 1ns/1ps
module cscg_cpu_model
(
	input  wire logic	clk,
	input  wire logic	phase_one,
	input  wire logic	ready_to_cpu,
	output logic		cycle_sync,
	output logic		data_bus_in_strobe,
	output logic		processor_write_strobe_n,
	output logic [7:0]	cpu_data_in
);
	initial
	begin
		cycle_sync = 1'b0;
		data_bus_in_strobe = 1'b0;
		processor_write_strobe_n = 1'b1;
		cpu_data_in = 8'h00;
	end
	// runs a cycle up to its data strobe and leaves the strobe asserted
	task automatic start_cycle(input logic [7:0] st, input logic [7:0] wd);
		int n;
		n = 0;
		@(negedge clk);
		while (!phase_one && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		cycle_sync = 1'b1;
		cpu_data_in = st;
		repeat (3) @(negedge clk);
		cycle_sync = 1'b0;
		while (!ready_to_cpu && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		data_bus_in_strobe = st[1];
		processor_write_strobe_n = st[1];
		// a released bus shows the inverse of its last value
		cpu_data_in = st[1] ? ~st : wd;
		repeat (3) @(negedge clk);
	endtask
	task automatic end_cycle();
		@(negedge clk);
		data_bus_in_strobe = 1'b0;
		processor_write_strobe_n = 1'b1;
		cpu_data_in = ~cpu_data_in;
	endtask
endmodule // cscg_cpu_model

// ==== tb_top.sv ====
// self-checking bench for the controller and clock generator
`timescale 1ns/1ps
module tb_top;
	logic		clk, nrst, reset_request_n, ready_request, cycle_sync, data_bus_in_strobe;
	logic		processor_write_strobe_n, hold_acknowledge, bus_drive_enable, auto_restart;
	logic		cpu_data_oe, sys_data_oe, phase_one, phase_two, phase_two_ttl, status_strobe_n;
	logic		system_reset, ready_to_cpu, memory_read_cmd_n, memory_write_cmd_n;
	logic		port_read_cmd_n, port_write_cmd_n, irq_acknowledge_cmd_n;
	logic [7:0]	cpu_data_in, cpu_data_out, sys_data_in, sys_data_out;
	int		err_total, samples_checked;
	cscg_top #(.POR_CYCLES(4)) uut (
		.clk                      (clk),
		.nrst                     (nrst),
		.reset_request_n          (reset_request_n),
		.ready_request            (ready_request),
		.cycle_sync               (cycle_sync),
		.data_bus_in_strobe       (data_bus_in_strobe),
		.processor_write_strobe_n (processor_write_strobe_n),
		.hold_acknowledge         (hold_acknowledge),
		.bus_drive_enable         (bus_drive_enable),
		.auto_restart             (auto_restart),
		.cpu_data_in              (cpu_data_in),
		.cpu_data_out             (cpu_data_out),
		.cpu_data_oe              (cpu_data_oe),
		.sys_data_in              (sys_data_in),
		.sys_data_out             (sys_data_out),
		.sys_data_oe              (sys_data_oe),
		.phase_one                (phase_one),
		.phase_two                (phase_two),
		.phase_two_ttl            (phase_two_ttl),
		.status_strobe_n          (status_strobe_n),
		.system_reset             (system_reset),
		.ready_to_cpu             (ready_to_cpu),
		.memory_read_cmd_n        (memory_read_cmd_n),
		.memory_write_cmd_n       (memory_write_cmd_n),
		.port_read_cmd_n          (port_read_cmd_n),
		.port_write_cmd_n         (port_write_cmd_n),
		.irq_acknowledge_cmd_n    (irq_acknowledge_cmd_n)
	);
	cscg_cpu_model cpu (
		.clk                      (clk),
		.phase_one                (phase_one),
		.ready_to_cpu             (ready_to_cpu),
		.cycle_sync               (cycle_sync),
		.data_bus_in_strobe       (data_bus_in_strobe),
		.processor_write_strobe_n (processor_write_strobe_n),
		.cpu_data_in              (cpu_data_in)
	);
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_reset_hold(input int min);
		int n;
		n = 0;
		check(system_reset === 1'b1 && status_strobe_n === 1'b0, "reset out");
		while (system_reset !== 1'b0 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		check(n >= min && n < 40, "reset length");
	endtask
	task automatic t_phases();
		int hi;
		hi = 0;
		repeat (18)
		begin
			@(negedge clk);
			hi += phase_one;
			check(phase_two_ttl === phase_two && !(phase_one && phase_two), "phases");
		end
		check(hi == 4, "divide by nine");
	endtask
	task automatic t_ready(input logic v);
		int n;
		n = 0;
		ready_request = v;
		while (ready_to_cpu !== v && n < 30)
		begin
			@(negedge clk);
			n++;
		end
		check(n >= 2 && n < 30, "ready sync");
	endtask
	task automatic t_cycle(input logic [7:0] st, input logic [4:0] en, input logic h,
		input logic [7:0] ed);
		hold_acknowledge = h;
		cpu.start_cycle(st, 8'hA5);
		check({memory_read_cmd_n, memory_write_cmd_n, port_read_cmd_n, port_write_cmd_n,
			irq_acknowledge_cmd_n} === en, "command");
		if (st[1])
			check(cpu_data_oe === !h && (h || cpu_data_out === ed), "to cpu");
		else
			check(sys_data_oe === !bus_drive_enable && sys_data_out === 8'hA5, "to bus");
		cpu.end_cycle();
		hold_acknowledge = 1'b0;
	endtask
	initial
	begin
		#100us;
		err_total++;
		$display("[FAIL] %0t watchdog", $time);
		tally_and_finish();
	end
	initial
	begin
		err_total = 0;
		samples_checked = 0;
		{nrst, hold_acknowledge, bus_drive_enable, auto_restart} = 4'h0;
		{reset_request_n, ready_request} = 2'h3;
		sys_data_in = 8'h3C;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		t_reset_hold(3);
		reset_request_n = 1'b0;
		repeat (6) @(negedge clk);
		reset_request_n = 1'b1;
		t_reset_hold(0);
		t_phases();
		t_ready(1'b0);
		t_ready(1'b1);
		t_cycle(8'h22, 5'h0F, 1'b0, 8'h3C);
		t_cycle(8'h00, 5'h17, 1'b0, 8'h00);
		t_cycle(8'h42, 5'h1B, 1'b0, 8'h3C);
		t_cycle(8'h10, 5'h1D, 1'b0, 8'h00);
		t_cycle(8'h0A, 5'h1F, 1'b0, 8'h3C);
		t_cycle(8'h23, 5'h1E, 1'b0, 8'h3C);
		bus_drive_enable = 1'b1;
		t_cycle(8'h10, 5'h1D, 1'b0, 8'h00);
		bus_drive_enable = 1'b0;
		t_cycle(8'h22, 5'h1F, 1'b1, 8'h3C);
		auto_restart = 1'b1;
		t_cycle(8'h23, 5'h1F, 1'b0, 8'hFF);
		tally_and_finish();
	end
endmodule // tb_top
